// File: core/sdram_cfg_lowpower.sv
// SDRAM geometry, timing gates, low-power policy and refresh error flag
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`include "sdram_cfg_defs.svh"
module sdram_cfg_lowpower
    import sdram_cfg_pkg::*;
#(
    parameter int IDLE_W = 8
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_code,
    input wire logic access_req,
    input wire logic access_busy,
    input wire logic refresh_req,
    input wire logic memory_clock_in,
    output logic act_ok,
    output logic rw_ok,
    output logic pre_ok,
    output logic cmd_ok,
    output logic mem_ready,
    output logic lp_cmd_stb,
    output logic [1:0] lp_cmd,
    output logic memory_clock_enable_pin,
    output logic memory_clock_pin,
    output logic irq,
    output logic [3:0] row_bits,
    output logic [2:0] bank_count,
    output logic [1:0] cas_latency,
    output logic bus_width_sel,
    output logic [2:0] partial_array_refresh,
    output logic [1:0] temp_comp_self_refresh,
    output logic [1:0] drive_strength,
    output logic [1:0] device_type
);
    // Idle counter must reach the longest timeout
    if (IDLE_W < 8)
    begin : g_bad_width
        $error("IDLE_W must be at least 8");
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        merge = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                merge[8*b +: 8] = nw[8*b +: 8];
            end
        end
    endfunction

    // Reserved codes are refused so the field keeps a usable setting
    function automatic logic [1:0] keep2(input logic [1:0] old, input logic [1:0] nw,
                                         input logic [1:0] bad);
        keep2 = (nw == bad) ? old : nw;
    endfunction

    logic ack_q;
    logic [31:0] dat_q;
    logic [31:0] geom_q;
    logic [31:0] geom_n;
    logic [31:0] lpctl_q;
    logic [31:0] lpctl_n;
    logic [1:0] dev_q;
    logic imr_q;
    logic imr_d;
    logic isr_q;
    logic isr_d;
    logic irq_q;
    logic pend_q;
    logic mclk_s1_q;
    logic mclk_s2_q;
    logic mclk_q;
    lp_state_e st_q;
    lp_state_e st_d;
    logic [1:0] sleep_mode_q;
    logic [1:0] lp_cmd_q;
    logic lp_stb_q;
    logic cke_q;
    logic ready_q;
    logic [IDLE_W-1:0] idle_q;
    logic act_ok_q;
    logic rw_ok_q;
    logic pre_ok_q;
    logic cmd_ok_q;
    logic [3:0] rows_q;
    logic [2:0] banks_q;

    // Bus decode
    wire bus_req = wb_cyc_i & wb_stb_i;
    wire bus_start = bus_req & ~ack_q;
    wire rd_start = bus_start & ~wb_we_i;
    wire wr_now = bus_req & wb_we_i & ack_q;
    wire hit_geom = wb_adr_i == `OFS_GEOM;
    wire hit_lpctl = wb_adr_i == `OFS_LPCTL;
    wire hit_set = wb_adr_i == `OFS_IRQ_SET;
    wire hit_clr = wb_adr_i == `OFS_IRQ_CLR;
    wire hit_mask = wb_adr_i == `OFS_IRQ_MASK;
    wire hit_stat = wb_adr_i == `OFS_IRQ_STAT;
    wire hit_dev = wb_adr_i == `OFS_DEVTYPE;
    wire bit0_wr = wr_now & wb_sel_i[0] & wb_dat_i[0];
    wire [31:0] geom_w = merge(geom_q, wb_dat_i, wb_sel_i);
    wire [31:0] lpctl_w = merge(lpctl_q, wb_dat_i, wb_sel_i) & `LPCTL_USED;
    wire [31:0] dev_w = merge({30'h0, dev_q}, wb_dat_i, wb_sel_i);
    wire [1:0] dev_n = dev_w[1] ? dev_q : dev_w[1:0];
    // Unmapped and write-only offsets read as zero
    wire [31:0] rd_mux = hit_geom ? geom_q :
                         hit_lpctl ? lpctl_q :
                         hit_mask ? {31'h0, imr_q} :
                         hit_stat ? {31'h0, isr_q} :
                         hit_dev ? {30'h0, dev_q} : 32'h0;

    always_comb
    begin
        geom_n = geom_w;
        geom_n[`F_ROWS] = keep2(geom_q[`F_ROWS], geom_w[`F_ROWS], 2'b11);
        geom_n[`F_LAT] = keep2(geom_q[`F_LAT], geom_w[`F_LAT], 2'b00);
        lpctl_n = lpctl_w;
        lpctl_n[`F_IDLE] = keep2(lpctl_q[`F_IDLE], lpctl_w[`F_IDLE], 2'b11);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end
        else
        begin
            ack_q <= bus_start;
            dat_q <= rd_start ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            geom_q <= `GEOM_RST;
            lpctl_q <= `LPCTL_RST;
            dev_q <= DEV_SDRAM;
        end
        else
        begin
            if (wr_now & hit_geom)
            begin
                geom_q <= geom_n;
            end
            if (wr_now & hit_lpctl)
            begin
                lpctl_q <= lpctl_n;
            end
            if (wr_now & hit_dev)
            begin
                dev_q <= dev_n;
            end
        end
    end

    // Refresh error: a new request while the last one is still unserved
    wire self_ref = (st_q == LP_SLEEP) && (sleep_mode_q != LPM_PWR_DOWN);
    wire ref_cmd = cmd_valid && (cmd_code == CMD_REF);
    wire ref_err = refresh_req & pend_q & ~ref_cmd;
    // Clear happens when the read data is captured, so no event slips in between
    assign isr_d = ref_err | (isr_q & ~(rd_start & hit_stat));
    assign imr_d = (bit0_wr & hit_set) | (imr_q & ~(bit0_wr & hit_clr));

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            imr_q <= 1'b0;
            isr_q <= 1'b0;
            irq_q <= 1'b0;
            pend_q <= 1'b0;
        end
        else
        begin
            imr_q <= imr_d;
            isr_q <= isr_d;
            irq_q <= isr_d & imr_d;
            pend_q <= (refresh_req & ~self_ref) | (pend_q & ~ref_cmd);
        end
    end

    // Low-power policy
    wire [1:0] lp_sel = lpctl_q[`F_LPSEL];
    wire deep_bad = (lp_sel == LPM_DEEP) && (dev_q != DEV_LOWPWR);
    wire [1:0] eff_mode = deep_bad ? LPM_OFF : lp_sel;
    wire [1:0] idle_code = lpctl_q[`F_IDLE];
    wire [IDLE_W-1:0] idle_lim = (idle_code == 2'b01) ? IDLE_W'(`IDLE_CYC_64) :
                                 (idle_code == 2'b10) ? IDLE_W'(`IDLE_CYC_128) :
                                 IDLE_W'(0);
    wire want_mem = access_req | access_busy | pend_q;
    wire idle_sat = idle_q >= idle_lim;

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            LP_ACTIVE:
            begin
                if ((eff_mode != LPM_OFF) && !want_mem && idle_sat)
                begin
                    st_d = LP_ENTER;
                end
            end
            LP_ENTER:
            begin
                st_d = LP_SLEEP;
            end
            LP_SLEEP:
            begin
                if (want_mem || (eff_mode != sleep_mode_q))
                begin
                    st_d = LP_WAKE;
                end
            end
            LP_WAKE:
            begin
                st_d = LP_ACTIVE;
            end
            default:
            begin
                st_d = LP_ACTIVE;
            end
        endcase
    end

    wire in_sleep_d = (st_d == LP_ENTER) || (st_d == LP_SLEEP);
    // Clock stops only for self-refresh and deep power-down
    wire clk_run_d = !((st_d == LP_SLEEP) && (sleep_mode_q != LPM_PWR_DOWN));

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_q <= LP_ACTIVE;
            sleep_mode_q <= LPM_OFF;
            lp_cmd_q <= LPM_OFF;
            lp_stb_q <= 1'b0;
            cke_q <= 1'b1;
            ready_q <= 1'b1;
            idle_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            if (st_d == LP_ENTER)
            begin
                sleep_mode_q <= eff_mode;
                lp_cmd_q <= eff_mode;
            end
            lp_stb_q <= st_d == LP_ENTER;
            cke_q <= !in_sleep_d;
            ready_q <= st_d == LP_ACTIVE;
            if (want_mem)
            begin
                idle_q <= '0;
            end
            else if (!idle_sat)
            begin
                idle_q <= idle_q + IDLE_W'(1);
            end
        end
    end

    // Memory clock arrives from another domain
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mclk_s1_q <= 1'b0;
            mclk_s2_q <= 1'b0;
            mclk_q <= 1'b0;
        end
        else
        begin
            mclk_s1_q <= memory_clock_in;
            mclk_s2_q <= mclk_s1_q;
            mclk_q <= mclk_s2_q & clk_run_d;
        end
    end

    // Command spacing timers
    wire is_act = cmd_valid && (cmd_code == CMD_ACT);
    wire sr_exit = (st_q == LP_SLEEP) && (st_d == LP_WAKE) && (sleep_mode_q != LPM_PWR_DOWN);
    wire [N_TIMERS-1:0] t_start = {sr_exit, is_act, is_act,
                                   cmd_valid && (cmd_code == CMD_PRE), ref_cmd,
                                   cmd_valid && (cmd_code == CMD_WR)};
    wire [3:0] t_load [N_TIMERS];
    wire [N_TIMERS-1:0] tz;
    assign t_load[T_WREC] = geom_q[`F_WREC];
    assign t_load[T_ROWCYC] = geom_q[`F_ROWCYC];
    assign t_load[T_PRECH] = geom_q[`F_PRECH];
    assign t_load[T_ACTRW] = geom_q[`F_ACTRW];
    assign t_load[T_ACTPRE] = geom_q[`F_ACTPRE];
    assign t_load[T_SREXIT] = geom_q[`F_SREXIT];

    for (genvar i = 0; i < N_TIMERS; i++)
    begin : g_timer
        logic [3:0] cnt_q;
        wire [3:0] cnt_d = t_start[i] ? t_load[i] :
                           (cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0;
        // Gate reopens one cycle early so the next command lands N edges later
        assign tz[i] = cnt_d <= 4'h1;
        always_ff @(posedge clk or posedge rst)
        begin
            if (rst)
            begin
                cnt_q <= 4'h0;
            end
            else
            begin
                cnt_q <= cnt_d;
            end
        end
    end

    wire rdy_d = st_d == LP_ACTIVE;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            act_ok_q <= 1'b1;
            rw_ok_q <= 1'b1;
            pre_ok_q <= 1'b1;
            cmd_ok_q <= 1'b1;
            rows_q <= 4'hb;
            banks_q <= 3'h2;
        end
        else
        begin
            act_ok_q <= rdy_d & tz[T_ROWCYC] & tz[T_PRECH] & tz[T_SREXIT];
            rw_ok_q <= rdy_d & tz[T_ACTRW] & tz[T_PRECH];
            pre_ok_q <= rdy_d & tz[T_ACTPRE] & tz[T_WREC] & tz[T_PRECH];
            cmd_ok_q <= rdy_d & tz[T_PRECH];
            rows_q <= 4'hb + {2'b00, geom_q[`F_ROWS]};
            banks_q <= geom_q[`F_BANKS] ? 3'h4 : 3'h2;
        end
    end

    assign wb_dat_o = dat_q;
    assign wb_ack_o = ack_q;
    assign act_ok = act_ok_q;
    assign rw_ok = rw_ok_q;
    assign pre_ok = pre_ok_q;
    assign cmd_ok = cmd_ok_q;
    assign mem_ready = ready_q;
    assign lp_cmd_stb = lp_stb_q;
    assign lp_cmd = lp_cmd_q;
    assign memory_clock_enable_pin = cke_q;
    assign memory_clock_pin = mclk_q;
    assign irq = irq_q;
    assign row_bits = rows_q;
    assign bank_count = banks_q;
    assign cas_latency = geom_q[`F_LAT];
    assign bus_width_sel = geom_q[`F_BUSW];
    assign partial_array_refresh = lpctl_q[`F_PARR];
    assign temp_comp_self_refresh = lpctl_q[`F_TEMP];
    assign drive_strength = lpctl_q[`F_DRIVE];
    assign device_type = dev_q;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_irq_follows: assert property (irq_q == (isr_q && imr_q))
        else $error("irq low while status and mask set");
    a_irq_set_en: assert property (bit0_wr && hit_set |=> imr_q)
        else $error("enable-set write did not enable");
    a_irq_clr_en: assert property (bit0_wr && hit_clr && !hit_set |=> !imr_q && !irq_q)
        else $error("enable-clear write did not disable");
    a_stat_rdclr: assert property (rd_start && hit_stat && !ref_err |=> !isr_q)
        else $error("status not cleared by read");
    a_lp_inhibit: assert property (lp_sel == LPM_OFF && st_q == LP_ACTIVE |=> !lp_stb_q)
        else $error("low-power command issued while inhibited");
    a_cke_sleep: assert property (st_q == LP_SLEEP |-> !cke_q && !lp_stb_q)
        else $error("clock enable high while asleep");
    a_deep_only: assert property (lp_stb_q && lp_cmd_q == LPM_DEEP |-> dev_q == DEV_LOWPWR)
        else $error("deep power-down to standard memory");
    a_prech_wait: assert property (t_start[T_PRECH] && geom_q[`F_PRECH] > 4'h1 |=> !cmd_ok_q)
        else $error("command allowed right after precharge");
    a_act_rw_wait: assert property (is_act && geom_q[`F_ACTRW] > 4'h1 |=> !rw_ok_q)
        else $error("read or write allowed too soon after activate");
    a_act_pre_wait: assert property (is_act && geom_q[`F_ACTPRE] > 4'h2 |=> !pre_ok_q[*2])
        else $error("precharge allowed too soon after activate");
endmodule

// File: common/sdram_cfg_defs.svh
// Register offsets, field positions, reset values and counts of the SDRAM config block
// Overview of operation
// - Row field codes 00/01/10 give 11/12/13 row bits; 11 reserved; resets 11 bits.
// - Bank bit clear gives two banks, set gives four; resets to two.
// - Latency codes 01/10/11 give 1/2/3 cycles; 00 reserved; resets to two.
// - Bus width bit clear is 32-bit, set is 16-bit; resets to 16-bit.
// - Write recovery count 0..15 cycles enforced; resets to two.
// - Refresh to activate waits row-cycle count 0..15; resets to seven.
// - Precharge to any command waits precharge count 0..15; resets to three.
// - Activate to read or write waits row-to-column count; resets to two.
// - Activate to precharge waits activate-to-precharge count; resets to five.
// - Clock enable rising out of self-refresh waits exit count before activate; resets eight.
// - Low-power select 00 issues no power-down, self-refresh or deep power-down.
// - Select 01: self-refresh, memory clock stopped, clock enable low; leave per access.
// - Select 10: power-down after each access with clock enable low; leave per access.
// - Select 11: deep power-down, only with a low-power memory attached.
// - Partial array field goes to low-power memory at initialization.
// - Temperature and drive strength fields go to low-power memory at initialization.
// - Idle timeout 00 immediate, 01 64 cycles, 10 128 cycles; 11 reserved.
// - Writing one to enable-set bit 0 enables the refresh error interrupt.
// - Writing one to enable-clear bit 0 disables the refresh error interrupt.
// - Mask bit 0 reads one while the refresh error interrupt is enabled.
// - Status bit shows a refresh error since last read; reading clears it.
// - Device type 00 standard SDRAM, 01 low-power SDRAM; 10 and 11 reserved.
`ifndef SDRAM_CFG_DEFS_SVH
`define SDRAM_CFG_DEFS_SVH
`define OFS_GEOM 8'h08
`define OFS_LPCTL 8'h10
`define OFS_IRQ_SET 8'h14
`define OFS_IRQ_CLR 8'h18
`define OFS_IRQ_MASK 8'h1c
`define OFS_IRQ_STAT 8'h20
`define OFS_DEVTYPE 8'h24
`define GEOM_RST 32'h852372c0
`define LPCTL_RST 32'h00000000
`define LPCTL_USED 32'h00003f73
`define F_ROWS 3:2
`define F_BANKS 4
`define F_LAT 6:5
`define F_BUSW 7
`define F_WREC 11:8
`define F_ROWCYC 15:12
`define F_PRECH 19:16
`define F_ACTRW 23:20
`define F_ACTPRE 27:24
`define F_SREXIT 31:28
`define F_LPSEL 1:0
`define F_PARR 6:4
`define F_TEMP 9:8
`define F_DRIVE 11:10
`define F_IDLE 13:12
`define F_DEV 1:0
`define IDLE_CYC_64 8'h40
`define IDLE_CYC_128 8'h80
`endif

// File: common/sdram_cfg_pkg.sv
// Types shared by the SDRAM config and low-power block
package sdram_cfg_pkg;
    typedef enum logic [2:0] {
        LP_ACTIVE = 3'b000,
        LP_ENTER = 3'b001,
        LP_SLEEP = 3'b010,
        LP_WAKE = 3'b011
    } lp_state_e;
    typedef enum logic [2:0] {
        CMD_NOP = 3'b000,
        CMD_ACT = 3'b001,
        CMD_RD = 3'b010,
        CMD_WR = 3'b011,
        CMD_PRE = 3'b100,
        CMD_REF = 3'b101
    } mem_cmd_e;
    typedef enum logic [1:0] {
        LPM_OFF = 2'b00,
        LPM_SELF_REF = 2'b01,
        LPM_PWR_DOWN = 2'b10,
        LPM_DEEP = 2'b11
    } lp_mode_e;
    typedef enum logic [1:0] {
        DEV_SDRAM = 2'b00,
        DEV_LOWPWR = 2'b01
    } dev_type_e;
    localparam int T_WREC = 0;
    localparam int T_ROWCYC = 1;
    localparam int T_PRECH = 2;
    localparam int T_ACTRW = 3;
    localparam int T_ACTPRE = 4;
    localparam int T_SREXIT = 5;
    localparam int N_TIMERS = 6;
endpackage

// File: testbench/sdram_mem_model.sv
// Behavioural SDRAM device: supplies the memory clock and logs low-power entries
module sdram_mem_model
    import sdram_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic memory_clock_pin,
    input wire logic lp_cmd_stb,
    input wire logic [1:0] lp_cmd,
    output logic memory_clock_in,
    output int entries,
    output int clk_edges,
    output logic [1:0] last_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    // Memory clock runs free; the block must gate it itself in self-refresh
    initial
    begin
        memory_clock_in = 1'b0;
        forever #160 memory_clock_in = ~memory_clock_in;
    end
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            entries <= 0;
            last_mode <= 2'h0;
        end
        else if (lp_cmd_stb === 1'b1)
        begin
            entries <= entries + 1;
            last_mode <= lp_cmd;
        end
    end
    // Counts pin edges so a clock that keeps running while asleep shows up
    always @(posedge memory_clock_pin or posedge rst)
        clk_edges <= rst ? 0 : clk_edges + 1;
endmodule

// File: testbench/test_sdram_cfg_lowpower.sv
// Self-checking bench: register bus, command gates, interrupt flag and low-power policy
`include "sdram_cfg_defs.svh"
module test_sdram_cfg_lowpower
    import sdram_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cmd_valid, access_req, access_busy;
    logic refresh_req, act_ok, rw_ok, pre_ok, cmd_ok, mem_ready, lp_cmd_stb, irq, bus_width_sel;
    logic memory_clock_enable_pin, memory_clock_pin, memory_clock_in;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i, row_bits, oks;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [2:0] cmd_code, bank_count, partial_array_refresh;
    logic [1:0] lp_cmd, cas_latency, temp_comp_self_refresh, drive_strength, device_type;
    logic [1:0] last_mode;
    int n_fail, tests_run, entries, clk_edges, k, snap;
    // Written low byte, read-back low byte, row bits, banks, latency, bus width
    logic [25:0] geo_tbl [9] = '{
        {8'hc0, 8'hc0, 4'hb, 3'h2, 2'h2, 1'h1}, {8'hc4, 8'hc4, 4'hc, 3'h2, 2'h2, 1'h1},
        {8'hc8, 8'hc8, 4'hd, 3'h2, 2'h2, 1'h1}, {8'hcc, 8'hc8, 4'hd, 3'h2, 2'h2, 1'h1},
        {8'hd8, 8'hd8, 4'hd, 3'h4, 2'h2, 1'h1}, {8'hb8, 8'hb8, 4'hd, 3'h4, 2'h1, 1'h1},
        {8'hf8, 8'hf8, 4'hd, 3'h4, 2'h3, 1'h1}, {8'h98, 8'hf8, 4'hd, 3'h4, 2'h3, 1'h1},
        {8'h58, 8'h58, 4'hd, 3'h4, 2'h2, 1'h0}};
    assign oks = {act_ok, rw_ok, pre_ok, cmd_ok};
    sdram_cfg_lowpower uut (
        .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .access_req(access_req), .access_busy(access_busy), .refresh_req(refresh_req),
        .memory_clock_in(memory_clock_in), .act_ok(act_ok), .rw_ok(rw_ok), .pre_ok(pre_ok),
        .cmd_ok(cmd_ok), .mem_ready(mem_ready), .lp_cmd_stb(lp_cmd_stb), .lp_cmd(lp_cmd),
        .memory_clock_enable_pin(memory_clock_enable_pin), .memory_clock_pin(memory_clock_pin),
        .irq(irq), .row_bits(row_bits), .bank_count(bank_count), .cas_latency(cas_latency),
        .bus_width_sel(bus_width_sel), .partial_array_refresh(partial_array_refresh),
        .temp_comp_self_refresh(temp_comp_self_refresh), .drive_strength(drive_strength),
        .device_type(device_type));
    sdram_mem_model mem (
        .clk(clk), .rst(rst), .memory_clock_pin(memory_clock_pin), .lp_cmd_stb(lp_cmd_stb),
        .lp_cmd(lp_cmd), .memory_clock_in(memory_clock_in), .entries(entries),
        .clk_edges(clk_edges), .last_mode(last_mode));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi)
        begin
            n_fail++;
            $display("[FAIL] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    // Classic single cycle; the request holds until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      input logic [3:0] sel);
        int t;
        t = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        @(posedge clk);
        while (wb_ack_o !== 1'b1 && t < 50)
        begin
            @(posedge clk);
            t++;
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        chk_rng(t, 0, 49);
    endtask
    // Issues one command and counts edges until its gate reopens
    task automatic gate(input logic [2:0] code, input int sel, input int n);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code <= code;
        @(posedge clk);
        cmd_valid <= 1'b0;
        k = 0;
        @(posedge clk);
        while (oks[sel] !== 1'b1 && k < 40)
        begin
            @(posedge clk);
            k++;
        end
        chk_rng(k, n - 1, n - 1);
        repeat (20) @(posedge clk);
    endtask
    task automatic ref_err();
        repeat (2)
        begin
            @(posedge clk);
            refresh_req <= 1'b1;
            @(posedge clk);
            refresh_req <= 1'b0;
        end
        repeat (3) @(posedge clk);
    endtask
    task automatic wake();
        @(posedge clk);
        access_req <= 1'b1;
        k = 0;
        while (mem_ready !== 1'b1 && k < 20)
        begin
            @(posedge clk);
            k++;
        end
        chk({mem_ready, memory_clock_enable_pin}, 32'h3);
    endtask
    // Idle counting starts when the access request drops
    task automatic enter(input logic [31:0] dat, input int lo, input int hi);
        wb(1'b1, `OFS_LPCTL, dat, 4'hf);
        @(posedge clk);
        access_req <= 1'b0;
        k = 0;
        while (lp_cmd_stb !== 1'b1 && k < 400)
        begin
            @(posedge clk);
            k++;
        end
        chk_rng(k, lo, hi);
        repeat (2) @(posedge clk);
    endtask
    task automatic print_verdict();
        $display("Checks run %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Whole run is near 1050 cycles
    initial
    begin
        #(6000 * 40);
        n_fail++;
        $display("[FAIL] %0t watchdog expired", $time);
        print_verdict();
    end
    initial
    begin
        {rst, wb_cyc_i, wb_stb_i, wb_we_i, cmd_valid, access_req, access_busy} = 7'h40;
        {wb_adr_i, wb_sel_i, wb_dat_i, cmd_code, refresh_req} = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, `OFS_GEOM, 32'h0, 4'hf);
        chk(rd, 32'h852372c0);
        chk({row_bits, bank_count, cas_latency, bus_width_sel}, geo_tbl[0][9:0]);
        wb(1'b0, `OFS_LPCTL, 32'h0, 4'hf);
        chk(rd, 32'h0);
        wb(1'b0, `OFS_IRQ_MASK, 32'h0, 4'hf);
        chk(rd, 32'h0);
        gate(CMD_ACT, 2, 2);
        gate(CMD_ACT, 1, 5);
        gate(CMD_PRE, 0, 3);
        gate(CMD_WR, 1, 2);
        wb(1'b1, `OFS_IRQ_SET, 32'h0, 4'hf);
        wb(1'b0, `OFS_IRQ_MASK, 32'h0, 4'hf);
        chk(rd, 32'h0);
        wb(1'b1, `OFS_IRQ_SET, 32'h1, 4'hf);
        wb(1'b0, `OFS_IRQ_MASK, 32'h0, 4'hf);
        chk(rd, 32'h1);
        ref_err();
        chk(irq, 32'h1);
        wb(1'b0, `OFS_IRQ_STAT, 32'h0, 4'hf);
        chk(rd, 32'h1);
        wb(1'b0, `OFS_IRQ_STAT, 32'h0, 4'hf);
        chk({rd[0], irq}, 32'h0);
        gate(CMD_REF, 3, 7);
        wb(1'b1, `OFS_IRQ_CLR, 32'h0, 4'hf);
        wb(1'b0, `OFS_IRQ_MASK, 32'h0, 4'hf);
        chk(rd, 32'h1);
        wb(1'b1, `OFS_IRQ_CLR, 32'h1, 4'hf);
        wb(1'b0, `OFS_IRQ_MASK, 32'h0, 4'hf);
        chk(rd, 32'h0);
        ref_err();
        chk(irq, 32'h0);
        wb(1'b0, `OFS_IRQ_STAT, 32'h0, 4'hf);
        chk(rd, 32'h1);
        gate(CMD_REF, 3, 7);
        wb(1'b1, 8'h40, 32'hffffffff, 4'hf);
        wb(1'b0, 8'h40, 32'h0, 4'hf);
        chk(rd, 32'h0);
        for (int i = 0; i < 9; i++)
        begin
            wb(1'b1, `OFS_GEOM, {24'h852372, geo_tbl[i][25:18]}, 4'hf);
            wb(1'b0, `OFS_GEOM, 32'h0, 4'hf);
            chk(rd, {24'h852372, geo_tbl[i][17:10]});
            chk({row_bits, bank_count, cas_latency, bus_width_sel}, geo_tbl[i][9:0]);
        end
        wb(1'b1, `OFS_LPCTL, 32'h000016ff, 4'h2);
        wb(1'b1, `OFS_LPCTL, 32'h00000050, 4'h1);
        wb(1'b0, `OFS_LPCTL, 32'h0, 4'hf);
        chk(rd, 32'h1650);
        chk({partial_array_refresh, temp_comp_self_refresh, drive_strength}, 32'h59);
        wake();
        enter(32'h1002, 64, 68);
        chk({lp_cmd, memory_clock_enable_pin, mem_ready}, 32'h8);
        wake();
        access_busy <= 1'b1;
        access_req <= 1'b0;
        snap = entries;
        repeat (100) @(posedge clk);
        chk_rng(entries - snap, 0, 0);
        access_busy <= 1'b0;
        wake();
        enter(32'h2001, 128, 132);
        chk({last_mode, memory_clock_enable_pin}, 32'h2);
        snap = clk_edges;
        repeat (40) @(posedge clk);
        chk_rng(clk_edges - snap, 0, 0);
        @(posedge clk);
        access_req <= 1'b1;
        k = 0;
        while (memory_clock_enable_pin !== 1'b1 && k < 20)
        begin
            @(posedge clk);
            k++;
        end
        chk(act_ok, 32'h0);
        k = 0;
        while (act_ok !== 1'b1 && k < 30)
        begin
            @(posedge clk);
            k++;
        end
        chk_rng(k, 6, 9);
        snap = clk_edges;
        repeat (40) @(posedge clk);
        chk_rng(clk_edges - snap, 2, 10);
        wb(1'b1, `OFS_DEVTYPE, 32'h2, 4'hf);
        wb(1'b0, `OFS_DEVTYPE, 32'h0, 4'hf);
        chk(rd, 32'h0);
        wb(1'b1, `OFS_LPCTL, 32'h3, 4'hf);
        access_req <= 1'b0;
        snap = entries;
        repeat (150) @(posedge clk);
        chk_rng(entries - snap, 0, 0);
        access_req <= 1'b1;
        wb(1'b1, `OFS_DEVTYPE, 32'h1, 4'hf);
        enter(32'h3, 2, 2);
        repeat (8) @(posedge clk);
        chk({device_type, last_mode, memory_clock_enable_pin}, 32'he);
        wake();
        wb(1'b1, `OFS_LPCTL, 32'h3000, 4'hf);
        wb(1'b0, `OFS_LPCTL, 32'h0, 4'hf);
        chk(rd, 32'h0);
        access_req <= 1'b0;
        snap = entries;
        repeat (150) @(posedge clk);
        chk_rng(entries - snap, 0, 0);
        chk(memory_clock_enable_pin, 32'h1);
        print_verdict();
    end
endmodule
